// ==== tb_wwd_core.sv ====
// self-checking testbench for the window watchdog core
`timescale 1ns/10ps
`include "wwd_defines.svh"
module tb_wwd_core;
    localparam int TRST = 200;
    localparam int WU = 400;
    // capacitor pin: high 15 cycles after release, 2 more to sync
    localparam int TCAP = (15 + 2) * `WWD_CAP_SCALE;
    // cycles from reset release to monitoring: evaluation, delay, settle
    localparam int TUP = `WWD_EVAL_CYC + TCAP + `WWD_SETTLE_CYC;
    // re-enable after a capacitor fault: full delay, then settle
    localparam int TRE = TCAP + `WWD_SETTLE_CYC;
    logic clk = 1'b0;
    logic cap_on = 1'b0;
    logic rst_n = 1'b0;
    logic kick_req = 1'b0;
    logic sel_a = 1'b0;
    logic sel_b = 1'b0;
    logic kick, r_out, r_oe, r_lvl, w_out, w_oe, w_lvl, flt_n;
    int error_cnt = 0;
    int checked = 0;
    int n;
    // --------
    // clock, design and host
    // --------
    always #50 clk = ~clk;
    // distinct lower bounds per code expose which ratio is latched
    wwd_core #(.TRST_PULLUP_CYC(TRST), .WDL_PU_00(100), .WDL_PU_11(200),
        .WDL_PU_01(300), .WDU_PU_00(WU), .WDU_PU_11(WU), .WDU_PU_01(WU))
    uut (.clk(clk), .rst_n(rst_n), .kick_input(kick),
        .ratio_select_a(sel_a), .ratio_select_b(sel_b),
        .reset_delay_option_pin_in(r_lvl),
        .reset_delay_option_pin_out(r_out),
        .reset_delay_option_pin_oe(r_oe),
        .window_timing_option_pin_in(w_lvl),
        .window_timing_option_pin_out(w_out),
        .window_timing_option_pin_oe(w_oe), .fault_output_n(flt_n));
    wwd_host_model host (.clk(clk), .cap_on(cap_on), .kick_req(kick_req),
        .kick_input(kick), .r_out(r_out), .r_oe(r_oe), .r_lvl(r_lvl),
        .w_out(w_out), .w_oe(w_oe), .w_lvl(w_lvl));
    // --------
    // tasks
    // --------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // bounded wait for the fault output to reach lvl; n holds the cycles
    task automatic wait_flt(input int lim, input logic lvl);
        n = 0;
        while (flt_n !== lvl && n < lim)
        begin
            @(posedge clk);
            n++;
        end
    endtask : wait_flt
    task automatic pulse();
        kick_req <= 1'b1;
        @(posedge clk);
        kick_req <= 1'b0;
    endtask : pulse
    // d quiet cycles with no fault, then one kick; d must be at least 4 after a previous kick
    task automatic kick_at(input int d);
        wait_flt(d, 1'b0);
        check(n, d);
        pulse();
    endtask : kick_at
    task automatic conclude();
        $display("error_cnt=%0d checked=%0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    // --------
    // tests
    // --------
    // hang guard, about 2.4 times the expected run
    initial
    begin
        #8000000;
        error_cnt++;
        conclude();
    end
    // main sequence; select changes kept 5000 cycles apart, except the last disable and re-enable
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        check(flt_n, 1'b1);
        check({r_oe, w_oe}, 2'h3);
        // evaluation, reset delay and settle pass quietly
        wait_flt(5600, 1'b0);
        check(n, 5600);
        // no first kick: fault near the upper bound
        wait_flt(400, 1'b0);
        check(n > 290 && n < 330, 1'b1);
        // a kick inside the fault must not shorten it
        repeat (50) @(posedge clk);
        pulse();
        wait_flt(TRST, 1'b1);
        check(n > 144 && n < 153, 1'b1);
        // code 00: first kick, then two inside the window
        kick_at(5);
        kick_at(150);
        kick_at(150);
        // early kick faults within a few cycles
        kick_at(50);
        wait_flt(10, 1'b0);
        check(n < 10, 1'b1);
        // disable during the fault releases the output at once
        sel_a <= 1'b1;
        wait_flt(6, 1'b1);
        check(n < 6, 1'b1);
        // disabled: even very early kicks are ignored
        kick_at(10);
        kick_at(10);
        kick_at(5000);
        // enable code 11; kicks during settle must not count
        sel_b <= 1'b1;
        kick_at(100);
        kick_at(150);
        kick_at(1300);
        // 150 is early against the 11 lower bound
        kick_at(150);
        wait_flt(10, 1'b0);
        check(n < 10, 1'b1);
        repeat (3400) @(posedge clk);
        // code 01 takes hold only at a fault release
        sel_a <= 1'b0;
        wait_flt(TRST + WU + 50, 1'b0);
        check(n < TRST + WU + 50, 1'b1);
        wait_flt(TRST + 10, 1'b1);
        check(n, TRST);
        kick_at(5);
        kick_at(250);
        wait_flt(10, 1'b0);
        check(n < 10, 1'b1);
        // second power-up: capacitor on the reset-delay pin, code 00
        repeat (5000) @(posedge clk);
        rst_n <= 1'b0;
        cap_on <= 1'b1;
        sel_b <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        check({flt_n, r_oe, w_oe}, 3'h7);
        wait_flt(TUP + WU + 200, 1'b0);
        check(n > TUP && n < TUP + WU + 20, 1'b1);
        // disable in the fault releases at once; re-enable owes a delay
        sel_a <= 1'b1;
        wait_flt(6, 1'b1);
        check(n < 6, 1'b1);
        repeat (10) @(posedge clk);
        sel_a <= 1'b0;
        wait_flt(TRE + WU + 50, 1'b0);
        check(n > TRE && n < TRE + WU + 20, 1'b1);
        wait_flt(TCAP + 10, 1'b1);
        check(n, TCAP);
        conclude();
    end
endmodule : tb_wwd_core

// ==== wwd_core.sv ====
// window watchdog sequencer: power-up, enable, window checks, fault output
`timescale 1ns/10ps
`include "wwd_defines.svh"
// Contract
// R1: classify reset-delay pin at power-up, 381us
// R2: classify window-timing pin at power-up, 381us
// R3: enable or disable acts immediately
// R4: ratio change waits for fault or reset
// R5: ignore kick 150us after enabling
// R6: capacitor delay: disable releases fault, reenable waits
// R7: fixed delay: reenable follows normal enable
// R8: four modes: off, 1:8, 3:4, 1:2
// R9: a high, b low disables
// R10: disabled: output high, kicks ignored
// R11: host spaces select changes 500us apart
// R12: only kick falling edges count
// R13: host kicks first before upper bound
// R14: host kicks later inside the window
// R15: early or missing kick drives fault low
// R16: fault suspends watchdog, ignores kicks
// R17: fault held low full reset delay
// R18: codes 00 eighth, 11 half, 01 three quarters
// R19: power-up waits one reset delay first
// R20: late first kick asserts fault
// R21: all periods from counters on one clock
// R22: kick and selects synchronised before use
module wwd_core
    import wwd_pkg::*;
#(
    parameter logic [31:0] TRST_OPEN_CYC = `WWD_US2CYC(`WWD_TRST_OPEN_US),
    parameter logic [31:0] TRST_PULLUP_CYC = `WWD_US2CYC(`WWD_TRST_PULLUP_US),
    parameter logic [31:0] WDL_OPEN_00 = `WWD_US2CYC(`WWD_WDL_OPEN_00_US),
    parameter logic [31:0] WDL_OPEN_01 = `WWD_US2CYC(`WWD_WDL_OPEN_01_US),
    parameter logic [31:0] WDL_OPEN_11 = `WWD_US2CYC(`WWD_WDL_OPEN_11_US),
    parameter logic [31:0] WDU_OPEN_00 = `WWD_US2CYC(`WWD_WDU_OPEN_00_US),
    parameter logic [31:0] WDU_OPEN_01 = `WWD_US2CYC(`WWD_WDU_OPEN_01_US),
    parameter logic [31:0] WDU_OPEN_11 = `WWD_US2CYC(`WWD_WDU_OPEN_11_US),
    parameter logic [31:0] WDL_PU_00 = `WWD_US2CYC(`WWD_WDL_PULLUP_00_US),
    parameter logic [31:0] WDL_PU_01 = `WWD_US2CYC(`WWD_WDL_PULLUP_01_US),
    parameter logic [31:0] WDL_PU_11 = `WWD_US2CYC(`WWD_WDL_PULLUP_11_US),
    parameter logic [31:0] WDU_PU_00 = `WWD_US2CYC(`WWD_WDU_PULLUP_00_US),
    parameter logic [31:0] WDU_PU_01 = `WWD_US2CYC(`WWD_WDU_PULLUP_01_US),
    parameter logic [31:0] WDU_PU_11 = `WWD_US2CYC(`WWD_WDU_PULLUP_11_US)
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic kick_input,
    input wire logic ratio_select_a,
    input wire logic ratio_select_b,
    input wire logic reset_delay_option_pin_in,
    output logic reset_delay_option_pin_out,
    output logic reset_delay_option_pin_oe,
    input wire logic window_timing_option_pin_in,
    output logic window_timing_option_pin_out,
    output logic window_timing_option_pin_oe,
    output logic fault_output_n
);
    localparam logic [31:0] SETTLE_CYC = 32'(`WWD_SETTLE_CYC);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // lower bound as a fraction of the upper one
    function automatic logic [31:0] wwd_ratio_lower(logic [31:0] upper,
                                                    logic [1:0] code);
        case (code)
            `WWD_SEL_R1_8: wwd_ratio_lower = upper >> 3; // R18
            `WWD_SEL_R3_4: wwd_ratio_lower = upper - (upper >> 2); // R18
            default: wwd_ratio_lower = upper >> 1; // R18
        endcase
    endfunction : wwd_ratio_lower

    // factory value by latched code
    function automatic logic [31:0] wwd_pick(logic [1:0] code,
        logic [31:0] v00, logic [31:0] v01, logic [31:0] v11);
        case (code)
            `WWD_SEL_R1_8: wwd_pick = v00;
            `WWD_SEL_R3_4: wwd_pick = v01;
            default: wwd_pick = v11;
        endcase
    endfunction : wwd_pick

    wwd_opt_if rst_opt ();
    wwd_opt_if win_opt ();

    // ------------------------------------------------------------------
    // option pin evaluation at power-up
    // ------------------------------------------------------------------
    wwd_opt_classifier u_rst_opt (
        .clk(clk),
        .rst_n(rst_n),
        .pin_in(reset_delay_option_pin_in),
        .pin_out(reset_delay_option_pin_out),
        .pin_oe(reset_delay_option_pin_oe),
        .res(rst_opt)
    ); // R1
    wwd_opt_classifier u_win_opt (
        .clk(clk),
        .rst_n(rst_n),
        .pin_in(window_timing_option_pin_in),
        .pin_out(window_timing_option_pin_out),
        .pin_oe(window_timing_option_pin_oe),
        .res(win_opt)
    ); // R2

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    logic k_s1_reg, k_s2_reg, k_s3_reg;
    logic [1:0] sel_s1_reg, sel_s2_reg;
    logic kick_fall, wd_off;

    // a third kick stage gives a clean edge without touching stage one
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            k_s1_reg <= 1'b0;
            k_s2_reg <= 1'b0;
            k_s3_reg <= 1'b0;
            sel_s1_reg <= 2'h0;
            sel_s2_reg <= 2'h0;
        end
        else
        begin
            k_s1_reg <= kick_input; // R22
            k_s2_reg <= k_s1_reg;
            k_s3_reg <= k_s2_reg;
            sel_s1_reg <= {ratio_select_a, ratio_select_b}; // R22
            sel_s2_reg <= sel_s1_reg;
        end
    end

    assign kick_fall = k_s3_reg & ~k_s2_reg; // R12
    assign wd_off = (sel_s2_reg == `WWD_SEL_OFF); // R9 R8

    // ------------------------------------------------------------------
    // periods for the classified options and latched code
    // ------------------------------------------------------------------
    logic [1:0] code_reg, code_next;
    logic [31:0] rst_delay, upper, lower;

    always_comb
    begin
        case (rst_opt.opt_class)
            WWD_OPT_PULLUP: rst_delay = TRST_PULLUP_CYC;
            WWD_OPT_CAP: rst_delay = 32'(rst_opt.charge_cnt) * `WWD_CAP_SCALE;
            default: rst_delay = TRST_OPEN_CYC;
        endcase
        case (win_opt.opt_class)
            WWD_OPT_PULLUP:
            begin
                upper = wwd_pick(code_reg, WDU_PU_00, WDU_PU_01, WDU_PU_11);
                lower = wwd_pick(code_reg, WDL_PU_00, WDL_PU_01, WDL_PU_11);
            end
            WWD_OPT_CAP:
            begin
                upper = 32'(win_opt.charge_cnt) * `WWD_CAP_SCALE;
                lower = wwd_ratio_lower(upper, code_reg);
            end
            default:
            begin
                upper = wwd_pick(code_reg, WDU_OPEN_00, WDU_OPEN_01,
                                 WDU_OPEN_11);
                lower = wwd_pick(code_reg, WDL_OPEN_00, WDL_OPEN_01,
                                 WDL_OPEN_11);
            end
        endcase
    end

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    wwd_state_t state_reg, state_next;
    logic [31:0] cnt_reg, cnt_next;
    logic hold_reg, hold_next;
    logic fault_n_reg, fault_n_next;
    logic cnt_end_rst, cnt_end_up;

    // counters run on the one clock; terminal counts chosen above
    assign cnt_end_rst = (cnt_reg >= rst_delay - 32'h1); // R21
    assign cnt_end_up = (cnt_reg >= upper - 32'h1); // R21

    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg + 32'h1;
        code_next = code_reg;
        hold_next = hold_reg;
        case (state_reg)
            WWD_S_EVAL:
            begin
                cnt_next = 32'h0;
                if (rst_opt.done && win_opt.done)
                begin
                    code_next = sel_s2_reg;
                    state_next = WWD_S_STARTUP;
                end
            end
            WWD_S_STARTUP:
            begin
                // inactive for one reset delay after power-up
                if (cnt_end_rst) // R19
                begin
                    cnt_next = 32'h0;
                    state_next = wd_off ? WWD_S_DISABLED : WWD_S_SETTLE;
                end
            end
            WWD_S_DISABLED:
            begin
                cnt_next = 32'h0;
                if (!wd_off)
                begin
                    code_next = sel_s2_reg; // R3
                    // capacitor delay owes a full period after a disable in fault, fixed does not
                    state_next = hold_reg ? WWD_S_HOLDOFF
                                          : WWD_S_SETTLE; // R6 R7
                    hold_next = 1'b0;
                end
            end
            WWD_S_HOLDOFF:
            begin
                if (cnt_end_rst) // R6
                begin
                    cnt_next = 32'h0;
                    state_next = WWD_S_SETTLE;
                end
            end
            WWD_S_SETTLE:
            begin
                // kicks ignored while the enable settles
                if (cnt_reg >= SETTLE_CYC - 32'h1) // R5
                begin
                    cnt_next = 32'h0;
                    state_next = WWD_S_FIRST;
                end
            end
            WWD_S_FIRST:
            begin
                // first kick: no lower bound applies
                if (kick_fall) // R13
                begin
                    cnt_next = 32'h0;
                    state_next = WWD_S_WINDOW;
                end
                else if (cnt_end_up) // R20 R15
                begin
                    cnt_next = 32'h0;
                    state_next = WWD_S_FAULT;
                end
            end
            WWD_S_WINDOW:
            begin
                if (kick_fall)
                begin
                    cnt_next = 32'h0;
                    if (cnt_reg < lower) // R15 R14
                        state_next = WWD_S_FAULT;
                end
                else if (cnt_end_up) // R15
                begin
                    cnt_next = 32'h0;
                    state_next = WWD_S_FAULT;
                end
            end
            WWD_S_FAULT:
            begin
                // kicks are not looked at here at all
                if (cnt_end_rst) // R16 R17
                begin
                    cnt_next = 32'h0;
                    code_next = sel_s2_reg; // R4
                    state_next = WWD_S_FIRST;
                end
            end
            default:
            begin
                cnt_next = 32'h0;
                state_next = WWD_S_EVAL;
            end
        endcase
        // disabling overrides everything once power-up is through
        if (wd_off && state_reg != WWD_S_EVAL
            && state_reg != WWD_S_STARTUP) // R3 R10
        begin
            if (state_reg == WWD_S_FAULT)
                hold_next = (rst_opt.opt_class == WWD_OPT_CAP); // R6
            state_next = WWD_S_DISABLED;
            cnt_next = 32'h0;
        end
        fault_n_next = (state_next != WWD_S_FAULT); // R10 R17
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg <= WWD_S_EVAL;
            cnt_reg <= 32'h0;
            code_reg <= 2'h0;
            hold_reg <= 1'b0;
            fault_n_reg <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            code_reg <= code_next;
            hold_reg <= hold_next;
            fault_n_reg <= fault_n_next;
        end
    end

    assign fault_output_n = fault_n_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_fault_release: assert property ( // R17
        $rose(fault_n_reg) |-> $past(wd_off) || $past(cnt_end_rst))
        else $error("fault released before reset delay");
    chk_disabled_high: assert property ( // R10
        wd_off && state_reg != WWD_S_EVAL && state_reg != WWD_S_STARTUP
        |=> fault_n_reg)
        else $error("fault output low while disabled");
    chk_disable_now: assert property ( // R3
        wd_off && state_reg inside {WWD_S_FIRST, WWD_S_WINDOW, WWD_S_FAULT}
        |=> state_reg == WWD_S_DISABLED)
        else $error("disable not taken at once");
    chk_settle_ignore: assert property ( // R5
        state_reg == WWD_S_SETTLE && kick_fall |=> state_reg != WWD_S_WINDOW)
        else $error("kick accepted during settling");
    chk_early_kick: assert property ( // R15
        state_reg == WWD_S_WINDOW && kick_fall && cnt_reg < lower && !wd_off
        |=> !fault_n_reg)
        else $error("early kick did not fault");
    chk_late_first: assert property ( // R20
        state_reg == WWD_S_FIRST && !kick_fall && cnt_end_up && !wd_off
        |=> state_reg == WWD_S_FAULT ##0 !fault_n_reg)
        else $error("missing first kick did not fault");
    chk_code_latch: assert property ( // R4
        $changed(code_reg) |-> $past(state_reg) inside
        {WWD_S_EVAL, WWD_S_FAULT, WWD_S_DISABLED})
        else $error("ratio changed outside a latch point");
    chk_fault_suspend: assert property ( // R16
        state_reg == WWD_S_FAULT && !wd_off && !cnt_end_rst
        |=> state_reg == WWD_S_FAULT)
        else $error("fault left early or kick honoured");
    chk_powerup_idle: assert property ( // R19
        state_reg inside {WWD_S_EVAL, WWD_S_STARTUP} |-> fault_n_reg)
        else $error("fault during power-up");
    chk_cap_holdoff: assert property ( // R6
        state_reg == WWD_S_DISABLED && hold_reg && !wd_off
        |=> state_reg == WWD_S_HOLDOFF)
        else $error("re-enable skipped reset delay");

    cov_good_kick: cover property (
        state_reg == WWD_S_WINDOW && kick_fall && cnt_reg >= lower);
    cov_fault: cover property ($fell(fault_n_reg));
    cov_reenable: cover property (
        state_reg == WWD_S_DISABLED ##1 state_reg == WWD_S_SETTLE);
    cov_holdoff: cover property (state_reg == WWD_S_HOLDOFF);
endmodule : wwd_core

// ==== wwd_defines.svh ====
// timing constants, pin encodings and counts for the window watchdog
`ifndef WWD_DEFINES_SVH
`define WWD_DEFINES_SVH

// ----------------------------------------------------------------------
// clock
// ----------------------------------------------------------------------
`define WWD_CLK_PERIOD_NS 100

// ----------------------------------------------------------------------
// times in their own units
// ----------------------------------------------------------------------
`define WWD_EVAL_US 381
`define WWD_SETTLE_US 150
`define WWD_SEL_SPACING_US 500
`define WWD_TRST_OPEN_US 200000
`define WWD_TRST_PULLUP_US 10000
`define WWD_WDL_OPEN_00_US 22500
`define WWD_WDL_OPEN_01_US 1850
`define WWD_WDL_OPEN_11_US 800000
`define WWD_WDU_OPEN_00_US 55000
`define WWD_WDU_OPEN_01_US 27500
`define WWD_WDU_OPEN_11_US 1600000
`define WWD_WDL_PULLUP_00_US 9000
`define WWD_WDL_PULLUP_01_US 9000
`define WWD_WDL_PULLUP_11_US 1850
`define WWD_WDU_PULLUP_00_US 109000
`define WWD_WDU_PULLUP_01_US 195000
`define WWD_WDU_PULLUP_11_US 11000

// ----------------------------------------------------------------------
// cycle counts derived from the times
// ----------------------------------------------------------------------
`define WWD_US2CYC(t) (((t) * 1000) / `WWD_CLK_PERIOD_NS)
`define WWD_EVAL_CYC `WWD_US2CYC(`WWD_EVAL_US)
`define WWD_SETTLE_CYC `WWD_US2CYC(`WWD_SETTLE_US)
`define WWD_SEL_SPACING_CYC `WWD_US2CYC(`WWD_SEL_SPACING_US)
`define WWD_DISCH_CYC (`WWD_EVAL_CYC / 2)
`define WWD_PU_SAMPLE_CYC 4
`define WWD_CAP_SCALE 64

// ----------------------------------------------------------------------
// select encodings {ratio_select_a, ratio_select_b}
// ----------------------------------------------------------------------
`define WWD_SEL_OFF 2'h2
`define WWD_SEL_R1_8 2'h0
`define WWD_SEL_R3_4 2'h1
`define WWD_SEL_R1_2 2'h3

`endif

// ==== wwd_host_model.sv ====
// host side model: kick pulse shaper, option pin pull-ups and capacitor
`timescale 1ns/10ps
module wwd_host_model (
    input wire logic clk,
    input wire logic cap_on,
    input wire logic kick_req,
    output logic kick_input,
    input wire logic r_out,
    input wire logic r_oe,
    output logic r_lvl,
    input wire logic w_out,
    input wire logic w_oe,
    output logic w_lvl
);
    logic [2:0] low_reg = 3'h0;
    logic [2:0] low_next;
    logic [3:0] chg_reg = 4'h0;
    logic [3:0] chg_next;
    // --------
    // kick pulse
    // --------
    // one request gives a four cycle low pulse, wide enough to sync
    always_comb
    begin
        low_next = low_reg;
        if (low_reg != 3'h0)
            low_next = low_reg - 3'h1;
        else if (kick_req)
            low_next = 3'h4;
    end
    always_ff @(posedge clk)
        low_reg <= low_next;
    assign kick_input = (low_reg == 3'h0);
    // --------
    // option pins
    // --------
    // a capacitor on the reset-delay pin climbs back 15 cycles after release
    always_comb
    begin
        chg_next = chg_reg;
        if (r_oe)
            chg_next = 4'h0;
        else if (chg_reg != 4'hf)
            chg_next = chg_reg + 4'h1;
    end
    always_ff @(posedge clk)
        chg_reg <= chg_next;
    // pull-ups: a pin reads high unless the device pulls it low or the reset-delay capacitor is still charging
    assign r_lvl = r_oe ? r_out : (!cap_on || chg_reg == 4'hf);
    assign w_lvl = w_oe ? w_out : 1'b1;
endmodule : wwd_host_model

// ==== wwd_opt_classifier.sv ====
// classifies one option pin as open, pulled up or capacitor loaded
`timescale 1ns/10ps
`include "wwd_defines.svh"
module wwd_opt_classifier
    import wwd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    wwd_opt_if.classifier res
);
    localparam logic [11:0] EVAL_LAST = 12'(`WWD_EVAL_CYC - 1);
    localparam logic [11:0] DISCH = 12'(`WWD_DISCH_CYC);
    localparam logic [11:0] PU_AT = 12'(`WWD_DISCH_CYC + `WWD_PU_SAMPLE_CYC);

    logic pin_s1_reg, pin_s2_reg;
    logic [11:0] cnt_reg, cnt_next;
    logic done_reg, done_next;
    logic oe_reg, oe_next;
    wwd_opt_class_t class_reg, class_next;
    logic [15:0] charge_reg, charge_next;

    // ------------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pin_s1_reg <= 1'b0;
            pin_s2_reg <= 1'b0;
        end
        else
        begin
            pin_s1_reg <= pin_in;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // ------------------------------------------------------------------
    // evaluation sequence: discharge, release, watch the pin climb
    // ------------------------------------------------------------------
    always_comb
    begin
        cnt_next = cnt_reg;
        done_next = done_reg;
        class_next = class_reg;
        charge_next = charge_reg;
        oe_next = 1'b0;
        if (!done_reg)
        begin
            cnt_next = cnt_reg + 12'h001;
            oe_next = (cnt_next < DISCH);
            // a pin already high just after release is a pull-up
            if (cnt_reg == PU_AT && pin_s2_reg)
                class_next = WWD_OPT_PULLUP;
            // a later rise means a capacitor charged up
            else if (cnt_reg > PU_AT && pin_s2_reg
                     && class_reg == WWD_OPT_OPEN)
            begin
                class_next = WWD_OPT_CAP;
                charge_next = 16'(cnt_reg - DISCH);
            end
            if (cnt_reg == EVAL_LAST)
            begin
                done_next = 1'b1; // R1 R2
                oe_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_reg <= 12'h000;
            done_reg <= 1'b0;
            class_reg <= WWD_OPT_OPEN;
            charge_reg <= 16'h0000;
            oe_reg <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_next;
            done_reg <= done_next;
            class_reg <= class_next;
            charge_reg <= charge_next;
            oe_reg <= oe_next;
        end
    end

    // only ever pulls the pin low; released once the discharge phase ends
    assign pin_out = 1'b0;
    assign pin_oe = oe_reg;
    assign res.done = done_reg;
    assign res.opt_class = class_reg;
    assign res.charge_cnt = charge_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    chk_eval_length: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(done_reg) |-> $past(cnt_reg) == EVAL_LAST) // R1
        else $error("evaluation did not take its full period");
    chk_release_after: assert property (@(posedge clk) disable iff (!rst_n)
        done_reg |-> !oe_reg) // R2
        else $error("option pin still driven after evaluation");
endmodule : wwd_opt_classifier

// ==== wwd_opt_if.sv ====
// result of one option pin evaluation, classifier to core
`timescale 1ns/10ps
interface wwd_opt_if;
    import wwd_pkg::*;
    logic done;
    wwd_opt_class_t opt_class;
    logic [15:0] charge_cnt;
    modport classifier (output done, output opt_class, output charge_cnt);
    modport core (input done, input opt_class, input charge_cnt);
endinterface : wwd_opt_if

// ==== wwd_pkg.sv ====
// types shared by the window watchdog modules
package wwd_pkg;
    // outcome of an option pin evaluation
    typedef enum logic [1:0] {
        WWD_OPT_OPEN,
        WWD_OPT_PULLUP,
        WWD_OPT_CAP
    } wwd_opt_class_t;

    // main sequencer states
    typedef enum logic [2:0] {
        WWD_S_EVAL,
        WWD_S_STARTUP,
        WWD_S_SETTLE,
        WWD_S_FIRST,
        WWD_S_WINDOW,
        WWD_S_FAULT,
        WWD_S_DISABLED,
        WWD_S_HOLDOFF
    } wwd_state_t;
endpackage : wwd_pkg
